// ---- hw/beam_scan_params.svh ----
// timing constants and sizes of the beam scan sequencer
`ifndef BEAM_SCAN_PARAMS_SVH
`define BEAM_SCAN_PARAMS_SVH
`define CLOCK_HZ 10000000
`define BEAM_TIME_NS 30000
`define OVERHEAD_TIME_NS 400000
`define MIN_CYCLE_TIME_NS 1000000
`define BEAM_CYCLES ((`BEAM_TIME_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define OVERHEAD_CYCLES ((`OVERHEAD_TIME_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define MIN_CYCLE_CYCLES ((`MIN_CYCLE_TIME_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define SETTLE_CYCLES 10
`define BEAM_COUNT 192
`define POWER_WIDTH 12
`define RATE_FAST_BPS 230400
`define RATE_SLOW_BPS 38400
`define BIT_FAST_CYCLES (`CLOCK_HZ / `RATE_FAST_BPS)
`define BIT_SLOW_CYCLES (`CLOCK_HZ / `RATE_SLOW_BPS)
`endif

// ---- hw/beam_scan_pkg.sv ----
// types of the beam scan sequencer
package beam_scan_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BEAM = 2'b01,
    ST_SEND = 2'b10,
    ST_WAIT = 2'b11
  } scan_state_type;

  typedef struct packed {
    logic fire;
    logic listen;
  } element_drive_type;
endpackage

// ---- hw/beam_scan_sequencer.sv ----
// beam scan sequencer: fires beams in turn, classifies them, ships results serially
`timescale 1ns/1ns
`include "beam_scan_params.svh"

// Behaviour
// RQ1 - beams are handled one at a time, never two together
// RQ2 - drive a beam's transmitter first, then enable only its paired receiver
// RQ3 - beam is free when measured power is above the switch-on threshold
// RQ4 - each beam takes 30 us from transmitter start to evaluation
// RQ5 - cycle lasts beams times 0.03 ms plus 0.4 ms overhead; code runs longer when the result frame outlasts 0.4 ms
// RQ6 - cycle is stretched to never last under 1 ms
// RQ7 - cycle evaluates all beams, then delivers results, before the next starts
// RQ8 - beam with power not above threshold is flagged interrupted
// RQ9 - result link runs at 230.4 kbit/s or 38.4 kbit/s
module beam_scan_sequencer #(
  parameter int BEAMS = `BEAM_COUNT,
  parameter int PWR_W = `POWER_WIDTH,
  parameter int MIN_CYCLES = `MIN_CYCLE_CYCLES,
  parameter int OVERHEAD_CYCLES = `OVERHEAD_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scan_enable,
  input wire logic rate_slow,
  input wire logic [PWR_W-1:0] switch_threshold,
  input wire logic [PWR_W-1:0] rx_power,
  output beam_scan_pkg::element_drive_type elem_drive_r [BEAMS],
  output logic [BEAMS-1:0] beam_free_r,
  output logic result_valid_r,
  output logic link_tx_r,
  output logic link_busy_r,
  output logic scan_active_r
);
  import beam_scan_pkg::*;

  localparam int BEAM_CYC = `BEAM_CYCLES;
  localparam int SETTLE = `SETTLE_CYCLES;
  localparam int CNT_W = $clog2(BEAMS * BEAM_CYC + OVERHEAD_CYCLES + MIN_CYCLES + 1);
  localparam int IDX_W = $clog2(BEAMS + 1);
  localparam int BIT_FAST = `BIT_FAST_CYCLES;
  localparam int BIT_SLOW = `BIT_SLOW_CYCLES;
  localparam int BAUD_W = $clog2(BIT_SLOW + 1);
  localparam int FRAME_BITS = BEAMS + 2;
  localparam int BIT_W = $clog2(FRAME_BITS + 1);
  localparam int NOM_CYC = BEAMS * BEAM_CYC + OVERHEAD_CYCLES;
  localparam int CYC_LEN = (NOM_CYC > MIN_CYCLES) ? NOM_CYC : MIN_CYCLES;

  localparam int BCNT_W = $clog2(BEAM_CYC);

  // refuse sizes the counters cannot serve
  if (BEAMS < 1) begin : g_bad_beams
    $error("beam_scan_sequencer: BEAMS must be at least 1");
  end

  if (PWR_W < 1) begin : g_bad_power
    $error("beam_scan_sequencer: PWR_W must be at least 1");
  end

  if (SETTLE < 1 || SETTLE >= BEAM_CYC - 1) begin : g_bad_settle
    $error("beam_scan_sequencer: settle time must fit inside a beam slot");
  end

  if (OVERHEAD_CYCLES < 1 || MIN_CYCLES < 1) begin : g_bad_cycle
    $error("beam_scan_sequencer: cycle lengths must be positive");
  end

  if (BIT_FAST < 2 || BIT_SLOW < BIT_FAST) begin : g_bad_rate
    $error("beam_scan_sequencer: link bit times too short for this clock");
  end

  scan_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cyc_cnt_r;
  logic [BCNT_W-1:0] beam_cnt_r;
  logic [IDX_W-1:0] idx_r;
  logic [BEAMS-1:0] work_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [BAUD_W-1:0] baud_r;
  logic [BIT_W-1:0] bits_r;

  // true when an index points at element pair g
  function automatic logic beam_selected(input logic [IDX_W-1:0] idx, input int unsigned g);
    beam_selected = idx == IDX_W'(g);
  endfunction

  // slot timing
  wire in_beam = state_r == ST_BEAM;
  wire in_send = state_r == ST_SEND;
  wire beam_done = beam_cnt_r == BCNT_W'(BEAM_CYC - 1); // RQ4
  wire listen_phase = beam_cnt_r >= BCNT_W'(SETTLE);
  wire listen_next = !beam_done && beam_cnt_r >= BCNT_W'(SETTLE - 1);
  wire last_beam = idx_r == IDX_W'(BEAMS - 1);
  wire scan_start = !in_beam && state_nxt == ST_BEAM;
  wire beam_phase_end = in_beam && state_nxt == ST_SEND;

  // next beam index, so a new transmitter fires on the first clock of its slot
  wire [IDX_W-1:0] idx_step = last_beam ? '0 : idx_r + 1'b1;
  wire [IDX_W-1:0] idx_held = in_beam ? idx_r : '0;
  wire [IDX_W-1:0] idx_nxt = (in_beam && beam_done) ? idx_step : idx_held; // RQ1

  // beam verdict merged into the collected states
  wire beam_is_free = rx_power > switch_threshold; // RQ3 RQ8
  wire beam_verdict = beam_is_free && listen_phase; // RQ3 RQ8
  wire [BEAMS-1:0] verdict_mask = BEAMS'(1) << idx_r;
  wire [BEAMS-1:0] verdict_bits = {BEAMS{beam_verdict}} & verdict_mask;
  wire [BEAMS-1:0] result_word = (work_r & ~verdict_mask) | verdict_bits;

  // link timing
  wire [BAUD_W-1:0] bit_len = rate_slow ? BAUD_W'(BIT_SLOW - 1) : BAUD_W'(BIT_FAST - 1); // RQ9
  wire baud_tick = baud_r == bit_len;
  wire last_bit = bits_r == BIT_W'(FRAME_BITS - 1);
  wire send_done = baud_tick && last_bit;
  wire cycle_over = cyc_cnt_r >= CNT_W'(CYC_LEN - 1); // RQ5 RQ6

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (scan_enable) state_nxt = ST_BEAM;
      ST_BEAM: if (beam_done && last_beam) state_nxt = ST_SEND; // RQ7
      ST_SEND: if (send_done) state_nxt = ST_WAIT;
      ST_WAIT: if (cycle_over) state_nxt = scan_enable ? ST_BEAM : ST_IDLE; // RQ6
    endcase
  end

  // one element pair active at a time, transmitter before receiver
  genvar g;
  generate
    for (g = 0; g < BEAMS; g++) begin : g_elem
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          elem_drive_r[g] <= '0;
        end else if (clk_en) begin
          elem_drive_r[g].fire <= state_nxt == ST_BEAM && beam_selected(idx_nxt, g); // RQ1 RQ2
          elem_drive_r[g].listen <= in_beam && beam_selected(idx_r, g) && listen_next; // RQ2
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      scan_active_r <= 1'b0;
      result_valid_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      scan_active_r <= state_nxt != ST_IDLE;
      result_valid_r <= beam_phase_end; // RQ7
    end
  end

  // cycle length counter, saturates so an idle block never wraps it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cyc_cnt_r <= '0;
    end else if (clk_en) begin
      cyc_cnt_r <= scan_start ? '0 : cyc_cnt_r + CNT_W'(!cycle_over); // RQ5 RQ6
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      beam_cnt_r <= '0;
      idx_r <= '0;
    end else if (clk_en) begin
      beam_cnt_r <= (in_beam && !beam_done) ? beam_cnt_r + 1'b1 : '0; // RQ4
      idx_r <= idx_nxt; // RQ1
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      work_r <= '0;
      beam_free_r <= '0;
    end else if (clk_en) begin
      if (in_beam && beam_done) work_r <= result_word; // RQ3 RQ8
      if (beam_phase_end) beam_free_r <= result_word; // RQ7
    end
  end

  // result frame: start bit, beam states (beam 0 first), stop bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_r <= '1;
      bits_r <= '0;
    end else if (clk_en) begin
      if (beam_phase_end) begin
        shift_r <= {1'b1, result_word, 1'b0}; // RQ7
        bits_r <= '0;
      end else if (in_send && baud_tick) begin
        shift_r <= {1'b1, shift_r[FRAME_BITS-1:1]};
        bits_r <= bits_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      baud_r <= '0;
    end else if (clk_en) begin
      baud_r <= (in_send && !baud_tick) ? baud_r + 1'b1 : '0; // RQ9
    end
  end

  // line idles high outside a frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_tx_r <= 1'b1;
      link_busy_r <= 1'b0;
    end else if (clk_en) begin
      link_tx_r <= in_send ? shift_r[0] : 1'b1; // RQ7
      if (beam_phase_end) begin
        link_busy_r <= 1'b1;
      end else if (in_send && send_done) begin
        link_busy_r <= 1'b0;
      end
    end
  end
endmodule // beam_scan_sequencer

// ---- tb/beam_array.sv ----
// model of the paired element array
`timescale 1ns/1ns
module beam_array #(
  parameter int BEAMS = 4
) (
  input logic clock,
  input beam_scan_pkg::element_drive_type elem_drive_r [BEAMS],
  input logic [BEAMS-1:0] blocked,
  output logic [11:0] rx_power
);
  logic [11:0] noise = '0;
  always_ff @(posedge clock) noise <= ~noise;
  always_comb begin
    rx_power = noise;
    for (int i = 0; i < BEAMS; i++)
      if (elem_drive_r[i].fire && elem_drive_r[i].listen) rx_power = 12'h800 + {11'h000, !blocked[i]};
  end
endmodule // beam_array

// ---- tb/beam_scan_sequencer_tb.sv ----
// bench of the beam scan sequencer
`timescale 1ns/1ns
module beam_scan_sequencer_tb;
  logic clock = 0, sys_rst = 1, rate_slow = 0, scan_enable = 1;
  logic result_valid_r, link_tx_r, link_busy_r, scan_active_r;
  logic [3:0] blocked = '0, beam_free_r;
  logic [11:0] rx_power, switch_threshold = 12'h800;
  beam_scan_pkg::element_drive_type elem_drive_r [4];
  int miscompares = 0, total_checks = 0;
  always #50 clock = ~clock;
  beam_scan_sequencer #(.BEAMS(4), .MIN_CYCLES(200), .OVERHEAD_CYCLES(50)) beam_scan_sequencer_inst (.clock, .sys_rst,
    .clk_en(1'b1), .scan_enable, .rate_slow, .switch_threshold, .rx_power, .elem_drive_r,
    .beam_free_r, .result_valid_r, .link_tx_r, .link_busy_r, .scan_active_r);
  beam_array beam_array_inst (.clock, .elem_drive_r, .blocked, .rx_power);
  task chk(input logic [5:0] seen, input logic [5:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask
  task scan(input logic [3:0] m, input logic s, input int b, input logic [11:0] t, input logic [3:0] e);
    logic [5:0] got;
    repeat (4000) if (link_busy_r !== 1'b0) @(negedge clock);
    @(posedge clock);
    blocked <= m;
    rate_slow <= s;
    switch_threshold <= t;
    repeat (4000) if (result_valid_r !== 1'b1) @(negedge clock);
    chk(beam_free_r, e);
    chk(scan_active_r, 1'b1);
    repeat (4000) if (link_tx_r !== 1'b0) @(negedge clock);
    repeat (b / 2) @(negedge clock);
    for (int i = 0; i < 6; i++) begin
      got[i] = link_tx_r;
      repeat (b) @(negedge clock);
    end
    chk(got, {1'b1, e, 1'b0});
  endtask
  task all_free; scan(4'h0, 1'b0, 43, 12'h800, 4'hF); endtask
  task alt_blocked_slow; scan(4'hA, 1'b1, 260, 12'h800, 4'h5); endtask
  task all_blocked_fast; scan(4'hF, 1'b0, 43, 12'h800, 4'h0); endtask
  task threshold_strict; scan(4'h0, 1'b0, 43, 12'h801, 4'h0); endtask
  task threshold_low; scan(4'hF, 1'b0, 43, 12'h7FF, 4'hF); endtask
  task stop_scan;
    logic [5:0] seen;
    @(posedge clock);
    scan_enable <= 1'b0;
    repeat (4000) if (scan_active_r !== 1'b0) @(negedge clock);
    chk(scan_active_r, 1'b0);
    seen = '0;
    repeat (400) begin
      @(negedge clock);
      for (int i = 0; i < 4; i++) seen[0] = seen[0] | elem_drive_r[i].fire;
      seen[1] = seen[1] | link_busy_r;
      seen[2] = seen[2] | !link_tx_r;
      seen[3] = seen[3] | result_valid_r;
    end
    chk(seen, 6'h00);
    @(posedge clock);
    scan_enable <= 1'b1;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (19) @(posedge clock);
    @(negedge clock);
    chk({scan_active_r, link_busy_r, result_valid_r, link_tx_r}, 6'h01);
    chk(beam_free_r, 6'h00);
    @(posedge clock);
    sys_rst <= 1'b0;
    all_free;
    alt_blocked_slow;
    stop_scan;
    all_blocked_fast;
    threshold_strict;
    threshold_low;
    close_out;
  end
  initial begin
    #4000000;
    miscompares++;
    close_out;
  end
endmodule // beam_scan_sequencer_tb
bind beam_scan_sequencer scan_asserts #(.BEAMS(BEAMS), .MIN_CYCLES(MIN_CYCLES), .OVERHEAD_CYCLES(OVERHEAD_CYCLES))
  scan_asserts_inst (.clock, .sys_rst, .elem_drive_r, .result_valid_r, .link_tx_r, .link_busy_r);

// ---- tb/scan_asserts.sv ----
// port checks of the beam scan sequencer
`timescale 1ns/1ns
module scan_asserts #(
  parameter int BEAMS = 4,
  parameter int MIN_CYCLES = 200,
  parameter int OVERHEAD_CYCLES = 50
) (
  input logic clock,
  input logic sys_rst,
  input beam_scan_pkg::element_drive_type elem_drive_r [BEAMS],
  input logic result_valid_r,
  input logic link_tx_r,
  input logic link_busy_r
);
  localparam int CYC = BEAMS * 300 + OVERHEAD_CYCLES;
  logic [BEAMS-1:0] f, l;
  int cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  always_comb for (int i = 0; i < BEAMS; i++) begin
    f[i] = elem_drive_r[i].fire;
    l[i] = elem_drive_r[i].listen;
  end
  // clocks since the last scan start
  always_ff @(posedge clock) cnt <= sys_rst ? CYC + MIN_CYCLES : $rose(f[0]) ? 1 : cnt + 1;
  a_one_beam: assert property ($onehot0(f)) else $error("overlap");
  a_rx_paired: assert property ((l & ~f) == '0) else $error("stray rx");
  a_rx_after: assert property ($rose(|l) |-> $past(f, 10) == l) else $error("rx early");
  a_beam_slot: assert property ($rose(f[0]) |-> ##299 f[0] ##1 f == BEAMS'(2)) else $error("slot");
  a_cycle_len: assert property ($rose(f[0]) |-> cnt >= CYC && cnt >= MIN_CYCLES) else $error("cycle");
  a_send_after: assert property (result_valid_r |-> f == '0 ##[0:2] link_busy_r) else $error("no frame");
  a_frame_quiet: assert property (link_busy_r |-> f == '0) else $error("beam in frame");
  a_bit_len: assert property ($fell(link_tx_r) |-> ##42 !link_tx_r) else $error("bit");
  cover property (result_valid_r);
  cover property ($rose(|l));
  cover property ($fell(link_tx_r));
endmodule // scan_asserts
